// File: rtl/ccb_regs.svh
`ifndef CCB_REGS_SVH
`define CCB_REGS_SVH
// Register indices; byte address is four times the index
`define CCB_IDX_RATE 7'h3b
`define CCB_IDX_TRIM 7'h3c
`define CCB_IDX_PLL 7'h3d
`define CCB_IDX_ODIV 7'h3e
`define CCB_IDX_STAT 7'h50
`define CCB_ADDR_W 9
// Reset values
`define CCB_RST_RATE 8'h7a
`define CCB_RST_TRIM 8'h00
`define CCB_RST_PLL 8'h00
`define CCB_RST_ODIV 8'h08
// Field positions
`define CCB_EXP_HI 7
`define CCB_EXP_LO 5
`define CCB_MAN_HI 4
`define CCB_MAN_LO 0
`define CCB_SEL_HI 7
`define CCB_SEL_LO 4
`define CCB_EN_BIT 3
`define CCB_PD_BIT 2
`define CCB_FB_HI 1
`define CCB_FB_LO 0
// Bit rate divisor terms
`define CCB_MAN_ADD_LOW 13'h0001
`define CCB_MAN_ADD_HIGH 13'h0021
`define CCB_ONE3 3'h1
// Feedback divider factors
`define CCB_FB_23 5'h17
`define CCB_FB_27 5'h1b
`define CCB_FB_28 5'h1c
`define CCB_FB_CODE_27 2'h1
`define CCB_FB_CODE_28 2'h2
// Lowest usable output divider
`define CCB_ODIV_MIN 8'h08
// Clock pin source codes
`define CCB_SRC_GPIO 4'h0
`define CCB_SRC_PLL 4'h1
`define CCB_SRC_LOW 4'h2
`define CCB_SRC_HIGH 4'h3
`define CCB_SRC_X1 4'h4
`define CCB_SRC_X2 4'h5
`define CCB_SRC_X4 4'h6
`define CCB_SRC_X8 4'h7
`define CCB_SRC_T0 4'h8
`define CCB_SRC_T3 4'hb
// Xtal divider masks (toggle every 1, 2, 4, 8 cycles)
`define CCB_MASK_X1 3'h0
`define CCB_MASK_X2 3'h1
`define CCB_MASK_X4 3'h3
`define CCB_MASK_X8 3'h7
// Framing
`define CCB_DATA_BITS_M1 3'h7
// AXI responses
`define CCB_RESP_OK 2'h0
`define CCB_RESP_ERR 2'h2
`define CCB_FIFO_DEPTH 8
`endif

// File: rtl/ccb_pkg.sv
package ccb_pkg;
  typedef enum logic [1:0] {UART_IDLE, UART_START, UART_DATA, UART_STOP} ccb_uart_state_t;
endpackage

// File: rtl/ccb_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module ccb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  // Handshakes and pointer update
  always_comb
  begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  assign in_ready = (count != (AW + 1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // Pointer registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage
  always_ff @(posedge aclk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule
`default_nettype wire

// File: rtl/ccb_clock_config.sv
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ccb_regs.svh"
module ccb_clock_config (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`CCB_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`CCB_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic serial_tx,
  input wire logic serial_rx,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_frame_error,
  input wire logic pll_clk_in,
  input wire logic [3:0] timer_overflow,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic clock_output_pin_o,
  output logic clock_output_pin_oe,
  input wire logic clock_output_pin_i,
  output logic clock_output_pin_in,
  output logic pll_power_down,
  output logic [4:0] pll_feedback_division,
  output logic [7:0] pll_output_division,
  output logic [7:0] slow_osc_trim_value
);
  ////////////////////////////////////////////////////////////////////////////////
  // Bit period in clock cycles from a rate setting
  function automatic logic [12:0] ccb_divisor(input logic [7:0] r);
    logic [2:0] e;
    logic [12:0] m;
    e = r[`CCB_EXP_HI:`CCB_EXP_LO];
    m = {8'h00, r[`CCB_MAN_HI:`CCB_MAN_LO]};
    if (e == '0)
      ccb_divisor = m + `CCB_MAN_ADD_LOW;
    else
      ccb_divisor = (m + `CCB_MAN_ADD_HIGH) << (e - `CCB_ONE3);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and AXI4-Lite slave
  logic [7:0] serial_bit_rate, low_freq_osc_trim, pll_and_clock_pin_control, output_divider_value;
  logic [7:0] next_serial_bit_rate, next_low_freq_osc_trim, next_pll_ctl, next_output_divider_value;
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [`CCB_ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [7:0] w_byte, next_w_byte;
  logic w_lane, next_w_lane;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [7:0] active_rate, next_active_rate;
  logic tx_busy, rx_busy;
  logic [6:0] widx, ridx;
  logic do_write;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Write capture, register update, read answer
  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_byte = w_byte;
    next_w_lane = w_lane;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    next_serial_bit_rate = serial_bit_rate;
    next_low_freq_osc_trim = low_freq_osc_trim;
    next_pll_ctl = pll_and_clock_pin_control;
    next_output_divider_value = output_divider_value;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_lane = s_axi_wstrb[0];
    end
    widx = aw_addr[`CCB_ADDR_W-1:2];
    do_write = aw_held && w_held && !s_axi_bvalid;
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `CCB_RESP_OK;
      case (widx)
        `CCB_IDX_RATE: if (w_lane) next_serial_bit_rate = w_byte;
        `CCB_IDX_TRIM: if (w_lane) next_low_freq_osc_trim = w_byte;
        `CCB_IDX_PLL: if (w_lane) next_pll_ctl = w_byte;
        `CCB_IDX_ODIV:
        begin
          if (w_lane && w_byte >= `CCB_ODIV_MIN)
            next_output_divider_value = w_byte;
        end
        `CCB_IDX_STAT: next_bresp = `CCB_RESP_OK;
        default: next_bresp = `CCB_RESP_ERR;
      endcase
    end
    ridx = s_axi_araddr[`CCB_ADDR_W-1:2];
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = `CCB_RESP_OK;
      case (ridx)
        `CCB_IDX_RATE: next_rdata = {24'h00_0000, serial_bit_rate};
        `CCB_IDX_TRIM: next_rdata = {24'h00_0000, low_freq_osc_trim};
        `CCB_IDX_PLL: next_rdata = {24'h00_0000, pll_and_clock_pin_control};
        `CCB_IDX_ODIV: next_rdata = {24'h00_0000, output_divider_value};
        `CCB_IDX_STAT: next_rdata = {22'h00_0000, rx_busy, tx_busy, active_rate};
        default:
        begin
          next_rdata = 32'h0000_0000;
          next_rresp = `CCB_RESP_ERR;
        end
      endcase
    end
  end

  // Bus and register state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CCB_RESP_OK;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `CCB_RESP_OK;
      s_axi_rdata <= 32'h0000_0000;
      serial_bit_rate <= `CCB_RST_RATE;
      low_freq_osc_trim <= `CCB_RST_TRIM;
      pll_and_clock_pin_control <= `CCB_RST_PLL;
      output_divider_value <= `CCB_RST_ODIV;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_byte <= next_w_byte;
      w_lane <= next_w_lane;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      serial_bit_rate <= next_serial_bit_rate;
      low_freq_osc_trim <= next_low_freq_osc_trim;
      pll_and_clock_pin_control <= next_pll_ctl;
      output_divider_value <= next_output_divider_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // PLL control outputs
  assign slow_osc_trim_value = low_freq_osc_trim;
  assign pll_power_down = pll_and_clock_pin_control[`CCB_PD_BIT];
  assign pll_output_division = output_divider_value;
  // Feedback factor; first stage is crystal times this, halved
  always_comb
  begin
    case (pll_and_clock_pin_control[`CCB_FB_HI:`CCB_FB_LO])
      `CCB_FB_CODE_27: pll_feedback_division = `CCB_FB_27;
      `CCB_FB_CODE_28: pll_feedback_division = `CCB_FB_28;
      default: pll_feedback_division = `CCB_FB_23;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO and serializer
  logic [7:0] fifo_data;
  logic fifo_valid, fifo_ready;
  ccb_pkg::ccb_uart_state_t tx_state, next_tx_state;
  logic [12:0] tx_cnt, next_tx_cnt;
  logic [2:0] tx_bit, next_tx_bit;
  logic [7:0] tx_shift, next_tx_shift;
  logic next_serial_tx;
  logic [12:0] period;

  ccb_fifo #(.WIDTH(8), .DEPTH(`CCB_FIFO_DEPTH)) u_tx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready)
  );

  assign period = ccb_divisor(active_rate);
  assign fifo_ready = (tx_state == ccb_pkg::UART_IDLE);
  assign tx_busy = (tx_state != ccb_pkg::UART_IDLE);

  // Frame: start, eight data LSB first, stop
  always_comb
  begin
    next_tx_state = tx_state;
    next_tx_cnt = tx_cnt;
    next_tx_bit = tx_bit;
    next_tx_shift = tx_shift;
    next_serial_tx = serial_tx;
    case (tx_state)
      ccb_pkg::UART_IDLE:
      begin
        next_serial_tx = 1'b1;
        if (fifo_valid)
        begin
          next_tx_shift = fifo_data;
          next_tx_cnt = period - 13'h0001;
          next_serial_tx = 1'b0;
          next_tx_state = ccb_pkg::UART_START;
        end
      end
      default:
      begin
        if (tx_cnt != '0)
          next_tx_cnt = tx_cnt - 13'h0001;
        else
        begin
          next_tx_cnt = period - 13'h0001;
          if (tx_state == ccb_pkg::UART_START)
          begin
            next_serial_tx = tx_shift[0];
            next_tx_bit = '0;
            next_tx_state = ccb_pkg::UART_DATA;
          end
          else if (tx_state == ccb_pkg::UART_DATA && tx_bit != `CCB_DATA_BITS_M1)
          begin
            next_tx_shift = tx_shift >> 1;
            next_serial_tx = tx_shift[1];
            next_tx_bit = tx_bit + `CCB_ONE3;
          end
          else if (tx_state == ccb_pkg::UART_DATA)
          begin
            next_serial_tx = 1'b1;
            next_tx_state = ccb_pkg::UART_STOP;
          end
          else
            next_tx_state = ccb_pkg::UART_IDLE;
        end
      end
    endcase
  end

  // Transmit state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_state <= ccb_pkg::UART_IDLE;
      tx_cnt <= '0;
      tx_bit <= '0;
      tx_shift <= 8'h00;
      serial_tx <= 1'b1;
    end
    else
    begin
      tx_state <= next_tx_state;
      tx_cnt <= next_tx_cnt;
      tx_bit <= next_tx_bit;
      tx_shift <= next_tx_shift;
      serial_tx <= next_serial_tx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive synchroniser and deserializer
  logic [2:0] rx_sync;
  logic [1:0] pll_sync;
  logic pll_s1;
  logic rx_level, next_rx_level;
  ccb_pkg::ccb_uart_state_t rx_state, next_rx_state;
  logic [12:0] rx_cnt, next_rx_cnt;
  logic [2:0] rx_bit, next_rx_bit;
  logic [7:0] rx_shift, next_rx_shift, next_rx_data;
  logic next_rx_valid, next_rx_frame_error;

  assign rx_busy = (rx_state != ccb_pkg::UART_IDLE);

  // Mid-bit sampling; no parity slot
  always_comb
  begin
    next_rx_level = (rx_sync[1] == rx_sync[2]) ? rx_sync[2] : rx_level;
    next_rx_state = rx_state;
    next_rx_cnt = rx_cnt;
    next_rx_bit = rx_bit;
    next_rx_shift = rx_shift;
    next_rx_data = rx_data;
    next_rx_valid = 1'b0;
    next_rx_frame_error = 1'b0;
    case (rx_state)
      ccb_pkg::UART_IDLE:
      begin
        if (!rx_level)
        begin
          next_rx_cnt = period >> 1;
          next_rx_state = ccb_pkg::UART_START;
        end
      end
      default:
      begin
        if (rx_cnt != '0)
          next_rx_cnt = rx_cnt - 13'h0001;
        else
        begin
          next_rx_cnt = period - 13'h0001;
          if (rx_state == ccb_pkg::UART_START)
          begin
            next_rx_bit = '0;
            next_rx_state = rx_level ? ccb_pkg::UART_IDLE : ccb_pkg::UART_DATA;
          end
          else if (rx_state == ccb_pkg::UART_DATA)
          begin
            next_rx_shift = {rx_level, rx_shift[7:1]};
            next_rx_bit = rx_bit + `CCB_ONE3;
            if (rx_bit == `CCB_DATA_BITS_M1)
              next_rx_state = ccb_pkg::UART_STOP;
          end
          else
          begin
            next_rx_state = ccb_pkg::UART_IDLE;
            if (rx_level)
            begin
              next_rx_data = rx_shift;
              next_rx_valid = 1'b1;
            end
            else
              next_rx_frame_error = 1'b1;
          end
        end
      end
    endcase
  end

  // Receive state and input synchronisers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_sync <= 3'h7;
      pll_s1 <= 1'b0;
      pll_sync <= 2'h0;
      rx_level <= 1'b1;
      rx_state <= ccb_pkg::UART_IDLE;
      rx_cnt <= '0;
      rx_bit <= '0;
      rx_shift <= 8'h00;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      rx_frame_error <= 1'b0;
    end
    else
    begin
      rx_sync <= {rx_sync[1:0], serial_rx};
      pll_s1 <= pll_clk_in;
      pll_sync <= {pll_sync[0], pll_s1};
      rx_level <= next_rx_level;
      rx_state <= next_rx_state;
      rx_cnt <= next_rx_cnt;
      rx_bit <= next_rx_bit;
      rx_shift <= next_rx_shift;
      rx_data <= next_rx_data;
      rx_valid <= next_rx_valid;
      rx_frame_error <= next_rx_frame_error;
    end
  end

  // Rate takes effect only with both directions idle
  always_comb
  begin
    next_active_rate = (!tx_busy && !rx_busy) ? serial_bit_rate : active_rate;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      active_rate <= `CCB_RST_RATE;
    else
      active_rate <= next_active_rate;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock output pin
  logic [3:0] sel;
  logic [2:0] div_cnt, next_div_cnt, mask;
  logic xtal_wave, next_xtal_wave, timer_wave, next_timer_wave, pll_level;
  logic next_pin_o, next_pin_oe, pin_en;
  logic [2:0] pin_sync;

  assign sel = pll_and_clock_pin_control[`CCB_SEL_HI:`CCB_SEL_LO];
  assign pin_en = pll_and_clock_pin_control[`CCB_EN_BIT];
  assign pll_level = (pll_sync[0] == pll_sync[1]) ? pll_sync[1] : clock_output_pin_o;

  // Crystal dividers, timer toggle and source select
  always_comb
  begin
    case (sel)
      `CCB_SRC_X2: mask = `CCB_MASK_X2;
      `CCB_SRC_X4: mask = `CCB_MASK_X4;
      `CCB_SRC_X8: mask = `CCB_MASK_X8;
      default: mask = `CCB_MASK_X1;
    endcase
    next_div_cnt = div_cnt + `CCB_ONE3;
    next_xtal_wave = ((div_cnt & mask) == mask) ? !xtal_wave : xtal_wave;
    next_timer_wave = timer_wave;
    if (sel >= `CCB_SRC_T0 && sel <= `CCB_SRC_T3 && timer_overflow[sel[1:0]])
      next_timer_wave = !timer_wave;
    next_pin_o = 1'b0;
    next_pin_oe = 1'b1;
    case (sel)
      `CCB_SRC_GPIO:
      begin
        next_pin_o = gpio_out;
        next_pin_oe = gpio_oe;
      end
      `CCB_SRC_PLL: next_pin_o = pin_en && pll_level;
      `CCB_SRC_LOW: next_pin_o = 1'b0;
      `CCB_SRC_HIGH: next_pin_o = 1'b1;
      `CCB_SRC_X1, `CCB_SRC_X2, `CCB_SRC_X4, `CCB_SRC_X8: next_pin_o = pin_en && xtal_wave;
      default:
      begin
        if (sel <= `CCB_SRC_T3)
          next_pin_o = pin_en && timer_wave;
        else
          next_pin_o = 1'b0;
      end
    endcase
  end

  // Pin and divider state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_cnt <= '0;
      xtal_wave <= 1'b0;
      timer_wave <= 1'b0;
      clock_output_pin_o <= 1'b0;
      clock_output_pin_oe <= 1'b0;
      clock_output_pin_in <= 1'b0;
      pin_sync <= 3'h0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      xtal_wave <= next_xtal_wave;
      timer_wave <= next_timer_wave;
      clock_output_pin_o <= next_pin_o;
      clock_output_pin_oe <= next_pin_oe;
      pin_sync <= {pin_sync[1:0], clock_output_pin_i};
      clock_output_pin_in <= (pin_sync[1] == pin_sync[2]) ? pin_sync[2] : clock_output_pin_in;
    end
  end
endmodule
`default_nettype wire

// File: verification/ccb_clock_config_checker.sv
`timescale 1ns/10ps
`default_nettype none
module ccb_clock_config_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_tx,
  input wire logic rx_valid,
  input wire logic rx_frame_error,
  input wire logic [4:0] pll_feedback_division,
  input wire logic [7:0] pll_output_division
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Bus transfer steps
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  ////////////////////////////////////////////////////////////
  chk_write_answer: assert property (s_wr_take |=> ##1 s_axi_bvalid)
    else $error("write response missing");
  chk_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read response missing");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  chk_fb_factor: assert property (pll_feedback_division inside {5'h17, 5'h1b, 5'h1c})
    else $error("bad feedback factor");
  chk_odiv_floor: assert property (pll_output_division >= 8'h08)
    else $error("output divider below eight");
  chk_rx_pulse: assert property (rx_valid |=> !rx_valid)
    else $error("receive strobe too long");
  chk_err_pulse: assert property (rx_frame_error |=> !rx_frame_error)
    else $error("error strobe too long");
  chk_tx_idle: assert property ($rose(aresetn) |-> serial_tx)
    else $error("line not idle after reset");
endmodule
bind ccb_clock_config ccb_clock_config_checker u_ccb_clock_config_checker (.*);
`default_nettype wire

// File: verification/ccb_uart_host.sv
`timescale 1ns/10ps
`default_nettype none
module ccb_uart_host (
  input wire logic aclk,
  input wire logic serial_tx,
  output var logic serial_rx
);
  int period = 236;
  initial serial_rx = 1'b1;
  // Send start, eight bits LSB first, stop
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge aclk);
      serial_rx <= f[i];
      repeat (period - 1) @(posedge aclk);
    end
    @(posedge aclk);
    serial_rx <= 1'b1;
  endtask
  // Receive a frame, timing the start bit
  task automatic recv(output logic [7:0] b, output int low, output logic s);
    int n;
    n = 0;
    low = 0;
    while (serial_tx === 1'b1 && n < 20000)
    begin
      @(negedge aclk);
      n++;
    end
    while (serial_tx === 1'b0 && low < 5000)
    begin
      @(negedge aclk);
      low++;
    end
    repeat (period / 2) @(negedge aclk);
    for (int i = 0; i < 8; i++)
    begin
      b[i] = serial_tx;
      repeat (period) @(negedge aclk);
    end
    s = serial_tx;
  endtask
endmodule
`default_nettype wire

// File: verification/tb_ccb_clock_config.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccb_regs.svh"
module tb_ccb_clock_config;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [8:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, timer_overflow = 4'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, tx_valid = 0, pll_clk_in = 0, gpio_out = 0, gpio_oe = 0;
  logic clock_output_pin_i = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, tx_ready, serial_tx, serial_rx, rx_valid;
  logic rx_frame_error, clock_output_pin_o, clock_output_pin_oe, clock_output_pin_in;
  logic pll_power_down, s, p;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [7:0] tx_data = '0, rx_data, pll_output_division, slow_osc_trim_value, b;
  logic [4:0] pll_feedback_division;
  logic [31:0] q;
  logic [4:0] fbt [4] = '{5'h17, 5'h1b, 5'h1c, 5'h17};
  int errors = 0, n_compared = 0, low, cnt, n, t;
  localparam logic [8:0] a_rate = {`CCB_IDX_RATE, 2'b00};
  localparam logic [8:0] a_trim = {`CCB_IDX_TRIM, 2'b00};
  localparam logic [8:0] a_pll = {`CCB_IDX_PLL, 2'b00};
  localparam logic [8:0] a_odiv = {`CCB_IDX_ODIV, 2'b00};
  localparam logic [8:0] a_stat = {`CCB_IDX_STAT, 2'b00};
  always #50 aclk = ~aclk;
  ccb_clock_config u_ccb_clock_config (.*);
  ccb_uart_host u_ccb_uart_host (.aclk(aclk), .serial_tx(serial_tx), .serial_rx(serial_rx));
  ////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus cycle, write or read
  task automatic bus(input logic wr, input logic [8:0] a, input logic [7:0] d);
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!(wr ? s_axi_bvalid : s_axi_rvalid) && n < 50);
    q = s_axi_rdata;
    rs = wr ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (n >= 50)
    begin
      errors++;
      stop_test;
    end
    @(negedge aclk);
  endtask
  task automatic rdc(input logic [8:0] a, input logic [7:0] e, input logic [1:0] r);
    bus(1'b0, a, 8'h00);
    chk("read data", {24'h00_0000, e}, q);
    chk("read resp", r, rs);
  endtask
  task automatic toggles(input int k);
    t = 0;
    p = clock_output_pin_o;
    repeat (k)
    begin
      @(negedge aclk);
      t += (clock_output_pin_o !== p);
      p = clock_output_pin_o;
    end
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdc(a_rate, 8'h7a, 2'b00);
    chk("line idle", 1, serial_tx);
    bus(1'b1, a_trim, 8'ha5);
    rdc(a_trim, 8'ha5, 2'b00);
    chk("trim port", 8'ha5, slow_osc_trim_value);
    bus(1'b1, a_odiv, 8'h07);
    rdc(a_odiv, 8'h08, 2'b00);
    bus(1'b1, a_odiv, 8'h09);
    chk("out divider", 8'h09, pll_output_division);
    rdc(9'h000, 8'h00, 2'b10);
    $display("registers done");
  endtask
  task automatic t_pin;
    for (int c = 0; c < 4; c++)
    begin
      bus(1'b1, a_pll, 8'h28 | c[7:0]);
      chk("fb factor", fbt[c], pll_feedback_division);
    end
    chk("pin low", 2'b10, {clock_output_pin_oe, clock_output_pin_o});
    bus(1'b1, a_pll, 8'h38);
    chk("pin high", 2'b11, {clock_output_pin_oe, clock_output_pin_o});
    bus(1'b1, a_pll, 8'hc8);
    toggles(16);
    chk("reserved pin", 2, {t[7:0], clock_output_pin_oe, clock_output_pin_o});
    for (int k = 4; k < 8; k++)
    begin
      bus(1'b1, a_pll, {k[3:0], 4'h8});
      toggles(64);
      chk("xtal toggles", 64 >> (k - 4), t);
    end
    bus(1'b1, a_pll, 8'h40);
    toggles(16);
    chk("gated pin", 0, {t[7:0], clock_output_pin_o});
    for (int i = 0; i < 8; i++)
    begin
      if (!i[0]) bus(1'b1, a_pll, {2'b10, i[2:1], 4'h8});
      p = clock_output_pin_o;
      @(posedge aclk);
      timer_overflow <= 4'h1 << (i[2:1] + 2'(i[0]));
      @(posedge aclk);
      timer_overflow <= 4'h0;
      repeat (3) @(negedge aclk);
      chk("timer toggle", p ^ !i[0], clock_output_pin_o);
    end
    @(posedge aclk);
    {gpio_out, gpio_oe, pll_clk_in, clock_output_pin_i} <= 4'hf;
    bus(1'b1, a_pll, 8'h04);
    chk("gpio pin", 4'hf,
      {clock_output_pin_in, pll_power_down, clock_output_pin_oe, clock_output_pin_o});
    bus(1'b1, a_pll, 8'h18);
    chk("pll pin", 3'h3, {pll_power_down, clock_output_pin_oe, clock_output_pin_o});
    $display("clock pin done");
  endtask
  task automatic t_uart;
    @(posedge aclk);
    tx_valid <= 1'b1;
    tx_data <= 8'ha5;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (!tx_ready && n < 20);
    tx_valid <= 1'b0;
    u_ccb_uart_host.recv(b, low, s);
    chk("frame", 9'h1a5, {s, b});
    chk("slow bit", 236, low);
    bus(1'b1, a_rate, 8'h15);
    bus(1'b0, a_stat, 8'h00);
    chk("rate held", 32'h0000_017a, q);
    cnt = 0;
    do
    begin
      bus(1'b0, a_stat, 8'h00);
      cnt++;
    end
    while (q[9:8] !== 2'b00 && cnt < 200);
    rdc(a_stat, 8'h15, 2'b00);
    u_ccb_uart_host.period = 22;
    cnt = 0;
    @(posedge aclk);
    tx_valid <= 1'b1;
    tx_data <= 8'h01;
    repeat (12)
    begin
      @(posedge aclk);
      if (tx_ready)
      begin
        cnt++;
        tx_data <= 8'h01 + 8'h10 * cnt[7:0];
      end
    end
    tx_valid <= 1'b0;
    chk("fifo full", 1, cnt >= 8 && !tx_ready);
    for (int i = 0; i < cnt; i++)
    begin
      u_ccb_uart_host.recv(b, low, s);
      chk("queued", {1'b1, 8'h01 + 8'h10 * i[7:0]}, {s, b});
      if (i > 0) chk("fast bit", 22, low);
    end
    n = 0;
    fork
      u_ccb_uart_host.send(8'h3c, 1'b1);
      while (rx_valid !== 1'b1 && n < 400)
      begin
        @(negedge aclk);
        n++;
      end
    join
    chk("rx byte", {1'b1, 8'h3c}, {n < 400, rx_data});
    n = 0;
    fork
      u_ccb_uart_host.send(8'h00, 1'b0);
      while (rx_frame_error !== 1'b1 && n < 400)
      begin
        @(negedge aclk);
        n++;
      end
    join
    chk("stop error", 1, n < 400);
    $display("serial done");
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_pin;
    t_uart;
    stop_test;
  end
endmodule
`default_nettype wire
